/* File: shared/stpcs_cfg.svh */
// Register offset, bit positions, clock select codes and prescaler tap masks
`ifndef STPCS_CFG_SVH
`define STPCS_CFG_SVH

// General timer control register
`define STPCS_GTC_OFFSET 8'h43
`define STPCS_GTC_RESET 8'h00
`define STPCS_BIT_SYNC_RST 0
`define STPCS_BIT_ASYNC_RST 1
`define STPCS_BIT_HOLD 7
`define STPCS_RSVD_ZERO 5'h00
`define STPCS_RDATA_IDLE 8'h00

// Clock select codes
`define STPCS_CS_NONE 3'h0
`define STPCS_CS_DIRECT 3'h1
`define STPCS_CS_DIV8 3'h2
`define STPCS_CS_DIV64 3'h3
`define STPCS_CS_DIV256 3'h4
`define STPCS_CS_DIV1024 3'h5
`define STPCS_CS_FALL 3'h6
`define STPCS_CS_RISE 3'h7

// Prescaler: width, reset value, step and tap masks
`define STPCS_PRE_W 10
`define STPCS_PRE_RESET 10'h000
`define STPCS_PRE_STEP 10'h001
`define STPCS_TAP8 10'h007
`define STPCS_TAP64 10'h03f
`define STPCS_TAP256 10'h0ff
`define STPCS_TAP1024 10'h3ff

// Number of timers sharing the prescaler
`define STPCS_NUM_TIMERS 2

`endif

/* File: shared/stpcs_pkg.sv */
// Types shared by the prescaler and clock select block
package stpcs_pkg;

  // Clock select field of one timer
  typedef logic [2:0] stpcs_cs_t;

  // Register port request
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stpcs_reg_req_t;

  // Whole state of the top module
  typedef struct packed {
    logic [9:0] prescaler;
    logic sync_hold_mode;
    logic async_prescaler_reset;
    logic sync_prescaler_reset;
    logic [1:0] count_clock;
    logic [7:0] rdata;
    logic [1:0] done_sync;
  } stpcs_state_t;

  // State of one pin sampler (posedge part)
  typedef struct packed {
    logic sampled;
    logic last;
  } stpcs_pin_state_t;

endpackage

/* File: core/stpcs_pin_sync.sv */
// Count pin sampler: low-phase hold, rising-edge sample, edge detector
module stpcs_pin_sync (
  input logic clk,
  input logic srst,
  input logic pin,
  output logic rise,
  output logic fall
);

  ////////////////////////////////////////////////////////////////////////////
  // Latch stage
  ////////////////////////////////////////////////////////////////////////////

  // Stands in for the latch open in the high phase: closes at the fall
  logic hold;

  // Half-cycle stage; read only by the next stage
  always_ff @(negedge clk) begin
    if (srst) begin
      hold <= 1'b0;
    end else begin
      hold <= pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample and edge detect
  ////////////////////////////////////////////////////////////////////////////

  stpcs_pkg::stpcs_pin_state_t st; // Current state
  stpcs_pkg::stpcs_pin_state_t next_st; // Next state

  // One sample per system clock, then one delay stage for the edge
  always_comb begin
    next_st = st;
    next_st.sampled = hold;
    next_st.last = st.sampled;
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edge pulses, one cycle each
  assign rise = st.sampled & ~st.last;
  assign fall = ~st.sampled & st.last;

endmodule

/* File: core/stpcs_top.sv */
// Shared timer prescaler, clock select and general timer control register
`include "stpcs_cfg.svh"

module stpcs_top (
  input logic clk,
  input logic srst,
  input stpcs_pkg::stpcs_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input stpcs_pkg::stpcs_cs_t [1:0] clock_select_field,
  input logic [1:0] external_count_pin,
  input logic async_mode,
  input logic async_reset_done,
  output logic [1:0] timer_count_clock,
  output logic sync_prescaler_reset,
  output logic async_prescaler_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  ////////////////////////////////////////////////////////////////////////////

  // True when every masked prescaler bit is one
  function automatic logic tap_hit(input logic [9:0] cnt, input logic [9:0] mask);
    tap_hit = ((cnt & mask) == mask);
  endfunction

  // Count pulse chosen by the clock select field
  function automatic logic pick_pulse(input stpcs_pkg::stpcs_cs_t cs, input logic [9:0] cnt,
                                      input logic rise, input logic fall);
    logic pulse;
    pulse = 1'b0;
    case (cs)
      `STPCS_CS_DIRECT: pulse = 1'b1;
      `STPCS_CS_DIV8: pulse = tap_hit(cnt, `STPCS_TAP8);
      `STPCS_CS_DIV64: pulse = tap_hit(cnt, `STPCS_TAP64);
      `STPCS_CS_DIV256: pulse = tap_hit(cnt, `STPCS_TAP256);
      `STPCS_CS_DIV1024: pulse = tap_hit(cnt, `STPCS_TAP1024);
      `STPCS_CS_FALL: pulse = fall;
      `STPCS_CS_RISE: pulse = rise;
      default: pulse = 1'b0;
    endcase
    pick_pulse = pulse;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////////////

  stpcs_pkg::stpcs_state_t st; // Current state
  stpcs_pkg::stpcs_state_t next_st; // Next state
  logic [1:0] pin_rise; // Rising edge per pin
  logic [1:0] pin_fall; // Falling edge per pin
  logic [1:0] sel_pulse; // Chosen pulse per timer
  logic wr_hit; // Write to the control register
  logic rd_hit; // Read of the control register

  assign wr_hit = reg_req.we && (reg_req.addr == `STPCS_GTC_OFFSET);
  assign rd_hit = reg_req.re && (reg_req.addr == `STPCS_GTC_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer pin sampler and clock select
  ////////////////////////////////////////////////////////////////////////////

  // Each timer reads the same prescaler but picks its own tap
  genvar gi;
  generate
    for (gi = 0; gi < `STPCS_NUM_TIMERS; gi = gi + 1) begin : g_timer
      stpcs_pin_sync u_stpcs_pin_sync (
        .clk(clk),
        .srst(srst),
        .pin(external_count_pin[gi]),
        .rise(pin_rise[gi]),
        .fall(pin_fall[gi])
      );
      // Edge pulses bypass the prescaler entirely
      assign sel_pulse[gi] = pick_pulse(clock_select_field[gi], st.prescaler,
                                        pin_rise[gi], pin_fall[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////////////////

  // Prescaler, control bits, count pulses and read data
  always_comb begin
    next_st = st;
    // Free running; selection never stops it, only the reset bit does
    if (st.sync_prescaler_reset) begin
      next_st.prescaler = `STPCS_PRE_RESET;
    end else begin
      next_st.prescaler = st.prescaler + `STPCS_PRE_STEP;
    end
    // Done may come from the third timer's own clock: two flops before use
    next_st.done_sync = {st.done_sync[0], async_reset_done};
    // Hardware clear of the reset bits outside hold mode
    if (!st.sync_hold_mode) begin
      next_st.sync_prescaler_reset = 1'b0;
      // Asynchronous third timer keeps the bit until its reset is done
      if (!async_mode || st.done_sync[1]) begin
        next_st.async_prescaler_reset = 1'b0;
      end
    end
    // Write comes last so a set in the clearing cycle wins
    if (wr_hit) begin
      next_st.sync_hold_mode = reg_req.wdata[`STPCS_BIT_HOLD];
      next_st.sync_prescaler_reset = reg_req.wdata[`STPCS_BIT_SYNC_RST];
      next_st.async_prescaler_reset = reg_req.wdata[`STPCS_BIT_ASYNC_RST];
    end
    // Registered count pulses
    // Extra flop gives the pin-to-counter delay its 2.5..3.5 cycle span
    next_st.count_clock = sel_pulse;
    // Read image; reserved bits are zero
    if (rd_hit) begin
      next_st.rdata = {st.sync_hold_mode, `STPCS_RSVD_ZERO, st.async_prescaler_reset,
                       st.sync_prescaler_reset};
    end else begin
      next_st.rdata = `STPCS_RDATA_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = st.rdata;
  assign timer_count_clock = st.count_clock;
  assign sync_prescaler_reset = st.sync_prescaler_reset;
  assign async_prescaler_reset = st.async_prescaler_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  // Direct select pulses every cycle
  property p_direct;
    @(posedge clk) disable iff (srst)
    (clock_select_field[0] == `STPCS_CS_DIRECT) |=> timer_count_clock[0];
  endproperty
  a_direct: assert property (p_direct) else $error("direct select missed a pulse");

  // Divide by 8 pulses only when low prescaler bits are all one
  property p_div8;
    @(posedge clk) disable iff (srst)
    (clock_select_field[1] == `STPCS_CS_DIV8) |=>
      (timer_count_clock[1] == ($past(st.prescaler[2:0]) == 3'h7));
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 tap wrong");

  // Prescaler counts up by one each cycle while not in reset
  property p_free_run;
    @(posedge clk) disable iff (srst)
    !st.sync_prescaler_reset |=> (st.prescaler == $past(st.prescaler) + `STPCS_PRE_STEP);
  endproperty
  a_free_run: assert property (p_free_run) else $error("prescaler did not advance");

  // Prescaler held at zero during its reset
  property p_pre_reset;
    @(posedge clk) disable iff (srst)
    st.sync_prescaler_reset |=> (st.prescaler == `STPCS_PRE_RESET);
  endproperty
  a_pre_reset: assert property (p_pre_reset) else $error("prescaler not reset");

  // Rising edge select follows the edge detector
  property p_rise;
    @(posedge clk) disable iff (srst)
    (clock_select_field[0] == `STPCS_CS_RISE) |=> (timer_count_clock[0] == $past(pin_rise[0]));
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge pulse wrong");

  // Hold mode keeps the reset bit set until a write
  property p_hold;
    @(posedge clk) disable iff (srst)
    (st.sync_hold_mode && st.sync_prescaler_reset && !wr_hit) |=> st.sync_prescaler_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("reset bit dropped in hold mode");

  // Leaving hold mode clears both bits together
  property p_release;
    @(posedge clk) disable iff (srst)
    (wr_hit && reg_req.wdata == `STPCS_GTC_RESET) |=> ##1
      (!st.sync_prescaler_reset && !st.async_prescaler_reset) || $past(wr_hit);
  endproperty
  a_release: assert property (p_release) else $error("bits not cleared on release");

  // Bit 0 alone is a one-cycle pulse
  property p_selfclear;
    @(posedge clk) disable iff (srst)
    (wr_hit && reg_req.wdata[`STPCS_BIT_SYNC_RST] && !reg_req.wdata[`STPCS_BIT_HOLD]) |=>
      st.sync_prescaler_reset ##1 (!st.sync_prescaler_reset || $past(wr_hit));
  endproperty
  a_selfclear: assert property (p_selfclear) else $error("reset bit did not self-clear");

  // No select gives no pulse
  property p_none;
    @(posedge clk) disable iff (srst)
    (clock_select_field[1] == `STPCS_CS_NONE) |=> !timer_count_clock[1];
  endproperty
  a_none: assert property (p_none) else $error("pulse with no select");

  // Reserved bits always read zero
  property p_rsvd;
    @(posedge clk) disable iff (srst)
    rd_hit |=> (reg_rdata[6:2] == `STPCS_RSVD_ZERO);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

endmodule

/* File: test/stpcs_timer_model.sv */
// Partner model: two timer units counting the selected count pulses
module stpcs_timer_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] count_pulse,
  output logic [1:0][15:0] count
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // One increment per pulse, as the downstream counters do
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (srst) begin
        count[i] <= 16'h0000;
      end else if (count_pulse[i]) begin
        count[i] <= count[i] + 16'h0001;
      end
    end
  end
endmodule

/* File: test/shared_timer_prescaler_clock_select_test.sv */
// Self-checking bench for the shared prescaler and clock select
`include "stpcs_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end

module shared_timer_prescaler_clock_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  stpcs_pkg::stpcs_reg_req_t req = '0;
  logic [7:0] rdata;
  stpcs_pkg::stpcs_cs_t [1:0] sel = '0;
  logic [1:0] pin = 2'b00;
  logic amode = 1'b0;
  logic adone = 1'b0;
  logic [1:0] tcc;
  logic sreset;
  logic areset;
  logic [1:0][15:0] cnt;
  logic [1:0][15:0] snap;
  logic [7:0] rv;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int l0;
  int l1;
  // Tap divisors for codes 2..5
  int div[4] = '{8, 64, 256, 1024};

  stpcs_top u_stpcs_top (.clk(clk), .srst(srst), .reg_req(req), .reg_rdata(rdata),
    .clock_select_field(sel), .external_count_pin(pin), .async_mode(amode),
    .async_reset_done(adone), .timer_count_clock(tcc), .sync_prescaler_reset(sreset),
    .async_prescaler_reset(areset));
  stpcs_timer_model u_stpcs_timer_model (.clk(clk), .srst(srst), .count_pulse(tcc), .count(cnt));

  ////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // Hang guard: whole run is well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Wait n edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.we <= 1'b0;
    #1;
  endtask

  // Read data is registered, valid the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.re <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Count pulses of both timers over n cycles
  task automatic window(input int n);
    snap = cnt;
    tick(n);
  endtask

  // Cycles until the first pulse of each timer, at most 80
  task automatic first_pulse();
    l0 = -1;
    l1 = -1;
    for (int i = 1; i <= 80; i++) begin
      tick(1);
      if (tcc[0] === 1'b1 && l0 < 0) l0 = i;
      if (tcc[1] === 1'b1 && l1 < 0) l1 = i;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(8);
    srst <= 1'b0;
    tick(1);
    rd(`STPCS_GTC_OFFSET, rv);
    `CHK(rv, `STPCS_GTC_RESET)
    // Hold mode keeps both resets; reserved bits dropped
    wr(`STPCS_GTC_OFFSET, 8'hff);
    rd(`STPCS_GTC_OFFSET, rv);
    `CHK(rv, 8'h83)
    `CHK({sreset, areset}, 2'b11)
    sel <= {`STPCS_CS_DIV8, `STPCS_CS_DIV8};
    window(40);
    `CHK(cnt - snap, 32'h0000_0000)
    // Release: both timers restart from one prescaler phase
    sel <= {`STPCS_CS_DIV64, `STPCS_CS_DIV8};
    wr(`STPCS_GTC_OFFSET, 8'h00);
    `CHK({sreset, areset}, 2'b00)
    first_pulse();
    `CHK(l1 - l0, 56)
    `CHK(l0 >= 1 && l0 <= 9, 1'b1)
    // Sync reset bit pulses for one cycle
    wr(`STPCS_GTC_OFFSET, 8'h01);
    `CHK(sreset, 1'b1)
    tick(1);
    `CHK(sreset, 1'b0)
    rd(`STPCS_GTC_OFFSET, rv);
    `CHK(rv, 8'h00)
    // Third timer reset waits for completion when asynchronous
    amode <= 1'b1;
    wr(`STPCS_GTC_OFFSET, 8'h02);
    tick(3);
    `CHK(areset, 1'b1)
    adone <= 1'b1;
    tick(3);
    `CHK(areset, 1'b0)
    amode <= 1'b0;
    adone <= 1'b0;
    wr(`STPCS_GTC_OFFSET, 8'h02);
    tick(1);
    `CHK(areset, 1'b0)
    // Unmapped address: write ignored, read zero
    wr(8'h44, 8'h81);
    rd(8'h44, rv);
    `CHK(rv, `STPCS_RDATA_IDLE)
    rd(`STPCS_GTC_OFFSET, rv);
    `CHK(rv, 8'h00)
    // All four taps, different per timer, whole periods
    for (int i = 0; i < 4; i++) begin
      sel <= {3'(5 - i), 3'(2 + i)};
      tick(2);
      window(1024);
      `CHK(cnt[0] - snap[0], 16'(1024 / div[i]))
      `CHK(cnt[1] - snap[1], 16'(1024 / div[3 - i]))
    end
    // Direct clock and no clock
    sel <= {`STPCS_CS_NONE, `STPCS_CS_DIRECT};
    tick(2);
    window(16);
    `CHK(cnt[0] - snap[0], 16'h0010)
    `CHK(cnt[1] - snap[1], 16'h0000)
    // Pin edges: select changed only on a stable pin
    sel <= {`STPCS_CS_FALL, `STPCS_CS_RISE};
    tick(4);
    @(posedge clk);
    pin <= 2'b11;
    first_pulse();
    `CHK(l0 >= 2 && l0 <= 3, 1'b1)
    `CHK(l1, -1)
    pin <= 2'b00;
    first_pulse();
    `CHK(l1 >= 2 && l1 <= 3, 1'b1)
    // Half period of 4 cycles, no division of the pin
    snap = cnt;
    for (int i = 0; i < 4; i++) begin
      pin <= 2'b11;
      tick(4);
      pin <= 2'b00;
      tick(4);
    end
    tick(4);
    `CHK(cnt[0] - snap[0], 16'h0004)
    `CHK(cnt[1] - snap[1], 16'h0004)
    summarize();
  end
endmodule
